// File: madp_defs.vh
`ifndef MADP_DEFS_VH
`define MADP_DEFS_VH

// Operation code width on the decoder port
`define MADP_OP_W        5

// Operation codes presented by the instruction decoder
`define MADP_OP_NONE     5'h00
`define MADP_OP_ADD_AI   5'h01
`define MADP_OP_ADD_AM   5'h02
`define MADP_OP_ADD_MA   5'h03
`define MADP_OP_ADDC_AM  5'h04
`define MADP_OP_ADDC_MA  5'h05
`define MADP_OP_ADDC_A   5'h06
`define MADP_OP_ADDC_M   5'h07
`define MADP_OP_NADD_AM  5'h08
`define MADP_OP_NADD_MA  5'h09
`define MADP_OP_SUB_AI   5'h0A
`define MADP_OP_SUB_AM   5'h0B
`define MADP_OP_SUB_MA   5'h0C
`define MADP_OP_SUBC_AM  5'h0D
`define MADP_OP_SUBC_MA  5'h0E
`define MADP_OP_SUBC_A   5'h0F
`define MADP_OP_SUBC_M   5'h10
`define MADP_OP_INC_M    5'h11
`define MADP_OP_DEC_M    5'h12
`define MADP_OP_CLR_M    5'h13
`define MADP_OP_MUL      5'h14

// Reset values
`define MADP_WORK_RST    8'h00
`define MADP_MULH_RST    8'h00
`define MADP_WDATA_RST   8'h00
`define MADP_FLAG_RST    1'b0

// Fixed operand constants
`define MADP_BYTE_ZERO   8'h00
`define MADP_BYTE_ONE    8'h01

`endif

// File: madp_arith_datapath.v
//Operation
// - Add immediate into working register, four flags
// - Add memory into working register, four flags
// - Add working register into memory byte
// - Add with carry, memory operand, either target
// - Add carry into working register
// - Add carry into memory byte
// - Negate working register, add memory, to register
// - Negate memory byte, add register, to memory
// - Subtract immediate from working register
// - Subtract memory byte from working register
// - Subtract working register from memory byte
// - Subtraction adds two's complement, shared adder
// - Subtract memory and borrow from register
// - Subtract register and borrow from memory
// - Subtract borrow from working register
// - Subtract borrow from memory byte
// - Increment memory byte, update four flags
// - Decrement memory byte, update four flags
// - Clear memory byte, flags unchanged
// - Unsigned 8x8 multiply, flags unchanged
// - Product high byte to high register, low to working
`timescale 1ns/1ns
`include "madp_defs.vh"

module madp_arith_datapath #(
  parameter DW = 8                   // Datapath width in bits
) (
  input  wire                  MCLK,            // Core clock, 50 MHz
  input  wire                  RST_N,           // Asynchronous reset, active low
  input  wire                  OP_VALID,        // Decoder presents an operation this cycle
  input  wire [`MADP_OP_W-1:0] OP_CODE,         // Operation selector
  input  wire [DW-1:0]         IMM_DATA,        // Immediate byte of the instruction
  input  wire [DW-1:0]         MEM_RDATA,       // Addressed data-memory byte
  input  wire [DW-1:0]         MUL_OPERAND,     // Second multiply operand
  input  wire                  WORK_LOAD,       // Plain load of the working register
  input  wire [DW-1:0]         WORK_LOAD_DATA,  // Value for a plain load
  output wire [DW-1:0]         WORK_REG,        // Working register
  output wire [DW-1:0]         MUL_RESULT_HIGH, // High byte of the last product
  output wire [DW-1:0]         MEM_WDATA,       // Byte to write back to memory
  output wire                  MEM_WE,          // One-cycle memory write strobe
  output wire                  OP_DONE,         // One-cycle completion pulse
  output wire                  RESULT_NULL,     // result_null_bit
  output wire                  UNSIGNED_OUT,    // unsigned_out_bit
  output wire                  NIBBLE_OUT,      // nibble_out_bit
  output wire                  SIGNED_WRAP      // signed_wrap_bit
);

  // Architectural state
  reg  [DW-1:0]   work_reg;          // Working register
  reg  [DW-1:0]   work_next;         // Next working register value
  reg  [DW-1:0]   mulh_reg;          // Multiply high result
  reg  [DW-1:0]   mulh_next;         // Next multiply high result
  reg  [DW-1:0]   wdata_reg;         // Memory write-back data
  reg  [DW-1:0]   wdata_next;        // Next write-back data
  reg             we_reg;            // Memory write strobe
  reg             we_next;           // Next write strobe
  reg             done_reg;          // Completion pulse
  reg             null_reg;          // Zero result flag
  reg             null_next;         // Next zero flag
  reg             uout_reg;          // Carry or borrow out of the top bit
  reg             uout_next;         // Next carry flag
  reg             nib_reg;           // Carry or borrow at bit 3
  reg             nib_next;          // Next nibble flag
  reg             wrap_reg;          // Signed overflow flag
  reg             wrap_next;         // Next overflow flag

  // Decoded controls
  reg  [DW-1:0]   opnd_x;            // First adder operand, the minuend
  reg  [DW-1:0]   opnd_y;            // Second operand before negation
  reg             sub_mode;          // Operation is a subtraction
  reg             use_carry;         // Current carry flag takes part
  reg             dst_mem;           // Result goes to memory, not register
  reg             do_arith;          // Adder result is stored with flags
  reg             do_clear;          // Memory byte is cleared
  reg             do_mul;            // Multiply is performed

  // Shared adder signals
  wire [DW-1:0]   addend_y;          // Second operand after negation
  wire            carry_in;          // Adder carry input
  wire [4:0]      low_sum;           // Low nibble sum with its carry
  wire [DW:0]     full_sum;          // Full sum with carry out
  wire [DW-1:0]   result;            // Eight-bit wrapped result
  wire            carry_out;         // Raw carry out of the top bit
  wire            half_carry;        // Raw carry out of bit 3
  wire            ovf;               // Two's-complement overflow
  wire [2*DW-1:0] product;           // Full multiply product

  // Decode the operation into operand choices and a destination
  always @* begin
    opnd_x    = work_reg;
    opnd_y    = `MADP_BYTE_ZERO;
    sub_mode  = 1'b0;
    use_carry = 1'b0;
    dst_mem   = 1'b0;
    do_arith  = 1'b0;
    do_clear  = 1'b0;
    do_mul    = 1'b0;
    case (OP_CODE)
      `MADP_OP_ADD_AI: begin               // Register plus immediate
        opnd_y   = IMM_DATA;
        do_arith = 1'b1;
      end
      `MADP_OP_ADD_AM: begin               // Register plus memory, into register
        opnd_y   = MEM_RDATA;
        do_arith = 1'b1;
      end
      `MADP_OP_ADD_MA: begin               // Register plus memory, into memory
        opnd_y   = MEM_RDATA;
        dst_mem  = 1'b1;
        do_arith = 1'b1;
      end
      `MADP_OP_ADDC_AM: begin              // With carry, into register
        opnd_y    = MEM_RDATA;
        use_carry = 1'b1;
        do_arith  = 1'b1;
      end
      `MADP_OP_ADDC_MA: begin              // With carry, into memory
        opnd_y    = MEM_RDATA;
        use_carry = 1'b1;
        dst_mem   = 1'b1;
        do_arith  = 1'b1;
      end
      `MADP_OP_ADDC_A: begin               // Register plus carry only
        use_carry = 1'b1;
        do_arith  = 1'b1;
      end
      `MADP_OP_ADDC_M: begin               // Memory plus carry only
        opnd_x    = MEM_RDATA;
        use_carry = 1'b1;
        dst_mem   = 1'b1;
        do_arith  = 1'b1;
      end
      `MADP_OP_NADD_AM: begin              // Memory minus register, into register
        opnd_x   = MEM_RDATA;
        opnd_y   = work_reg;
        sub_mode = 1'b1;
        do_arith = 1'b1;
      end
      `MADP_OP_NADD_MA: begin              // Register minus memory, into memory
        opnd_y   = MEM_RDATA;
        sub_mode = 1'b1;
        dst_mem  = 1'b1;
        do_arith = 1'b1;
      end
      `MADP_OP_SUB_AI: begin               // Register minus immediate
        opnd_y   = IMM_DATA;
        sub_mode = 1'b1;
        do_arith = 1'b1;
      end
      `MADP_OP_SUB_AM: begin               // Register minus memory
        opnd_y   = MEM_RDATA;
        sub_mode = 1'b1;
        do_arith = 1'b1;
      end
      `MADP_OP_SUB_MA: begin               // Memory minus register
        opnd_x   = MEM_RDATA;
        opnd_y   = work_reg;
        sub_mode = 1'b1;
        dst_mem  = 1'b1;
        do_arith = 1'b1;
      end
      `MADP_OP_SUBC_AM: begin              // Register minus memory and borrow
        opnd_y    = MEM_RDATA;
        sub_mode  = 1'b1;
        use_carry = 1'b1;
        do_arith  = 1'b1;
      end
      `MADP_OP_SUBC_MA: begin              // Memory minus register and borrow
        opnd_x    = MEM_RDATA;
        opnd_y    = work_reg;
        sub_mode  = 1'b1;
        use_carry = 1'b1;
        dst_mem   = 1'b1;
        do_arith  = 1'b1;
      end
      `MADP_OP_SUBC_A: begin               // Register minus borrow only
        sub_mode  = 1'b1;
        use_carry = 1'b1;
        do_arith  = 1'b1;
      end
      `MADP_OP_SUBC_M: begin               // Memory minus borrow only
        opnd_x    = MEM_RDATA;
        sub_mode  = 1'b1;
        use_carry = 1'b1;
        dst_mem   = 1'b1;
        do_arith  = 1'b1;
      end
      `MADP_OP_INC_M: begin                // Memory plus one
        opnd_x   = MEM_RDATA;
        opnd_y   = `MADP_BYTE_ONE;
        dst_mem  = 1'b1;
        do_arith = 1'b1;
      end
      `MADP_OP_DEC_M: begin                // Memory minus one, as a true subtraction
        opnd_x   = MEM_RDATA;
        opnd_y   = `MADP_BYTE_ONE;
        sub_mode = 1'b1;
        dst_mem  = 1'b1;
        do_arith = 1'b1;
      end
      `MADP_OP_CLR_M: begin                // Zero the memory byte
        dst_mem  = 1'b1;
        do_clear = 1'b1;
      end
      `MADP_OP_MUL: begin                  // Unsigned multiply
        do_mul = 1'b1;
      end
      default: begin                       // No operation, nothing changes
        do_arith = 1'b0;
      end
    endcase
  end

  // One adder serves every add and subtract: a subtraction feeds the
  // inverted subtrahend and an inverted borrow as carry input
  assign addend_y  = sub_mode ? ~opnd_y : opnd_y;
  assign carry_in  = sub_mode ? ~(use_carry & uout_reg)
                              : (use_carry & uout_reg);
  assign low_sum   = {1'b0, opnd_x[3:0]} + {1'b0, addend_y[3:0]} + {4'h0, carry_in};
  assign full_sum  = {1'b0, opnd_x} + {1'b0, addend_y} + {{DW{1'b0}}, carry_in};

  // The top carry bit is dropped, so results wrap modulo 256
  assign result    = full_sum[DW-1:0];
  assign carry_out = full_sum[DW];
  assign half_carry = low_sum[4];

  // Overflow when both inputs share a sign that the result lacks
  assign ovf = (opnd_x[DW-1] == addend_y[DW-1]) && (result[DW-1] != opnd_x[DW-1]);

  // Zero-extended operands keep the product a full sixteen bits
  assign product = {{DW{1'b0}}, work_reg} * {{DW{1'b0}}, MUL_OPERAND};

  // Next-state selection; flags change only for adder operations
  always @* begin
    work_next  = work_reg;
    mulh_next  = mulh_reg;
    wdata_next = wdata_reg;
    we_next    = 1'b0;
    null_next  = null_reg;
    uout_next  = uout_reg;
    nib_next   = nib_reg;
    wrap_next  = wrap_reg;
    if (OP_VALID) begin
      if (do_arith) begin
        null_next = (result == `MADP_BYTE_ZERO);
        // Subtraction reports borrow, the inverse of the adder carry
        uout_next = sub_mode ? ~carry_out : carry_out;
        nib_next  = sub_mode ? ~half_carry : half_carry;
        wrap_next = ovf;
        if (dst_mem) begin
          wdata_next = result;
          we_next    = 1'b1;
        end else begin
          work_next = result;
        end
      end else if (do_clear) begin
        // Flags are left alone on purpose
        wdata_next = `MADP_BYTE_ZERO;
        we_next    = 1'b1;
      end else if (do_mul) begin
        mulh_next = product[2*DW-1:DW];
        work_next = product[DW-1:0];
      end
    end else if (WORK_LOAD) begin
      // Plain loads yield to operations so one cycle never sees two writers
      work_next = WORK_LOAD_DATA;
    end
  end

  // State registers
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      work_reg  <= `MADP_WORK_RST;
      mulh_reg  <= `MADP_MULH_RST;
      wdata_reg <= `MADP_WDATA_RST;
      we_reg    <= 1'b0;
      done_reg  <= 1'b0;
      null_reg  <= `MADP_FLAG_RST;
      uout_reg  <= `MADP_FLAG_RST;
      nib_reg   <= `MADP_FLAG_RST;
      wrap_reg  <= `MADP_FLAG_RST;
    end else begin
      work_reg  <= work_next;
      mulh_reg  <= mulh_next;
      wdata_reg <= wdata_next;
      we_reg    <= we_next;
      // Completion pulses for any recognised operation
      done_reg  <= OP_VALID && (do_arith || do_clear || do_mul);
      null_reg  <= null_next;
      uout_reg  <= uout_next;
      nib_reg   <= nib_next;
      wrap_reg  <= wrap_next;
    end
  end

  // Outputs straight from registers
  assign WORK_REG        = work_reg;
  assign MUL_RESULT_HIGH = mulh_reg;
  assign MEM_WDATA       = wdata_reg;
  assign MEM_WE          = we_reg;
  assign OP_DONE         = done_reg;
  assign RESULT_NULL     = null_reg;
  assign UNSIGNED_OUT    = uout_reg;
  assign NIBBLE_OUT      = nib_reg;
  assign SIGNED_WRAP     = wrap_reg;

endmodule // madp_arith_datapath

// File: madp_arith_asserts.sv
`timescale 1ns/1ns
`include "madp_defs.vh"
// Pin-level checks; each ties a result to the request taken one edge before
module madp_arith_asserts #(
  parameter DW = 8  // Datapath width
) (
  input wire logic                  MCLK,
  input wire logic                  RST_N,
  input wire logic                  OP_VALID,
  input wire logic [`MADP_OP_W-1:0] OP_CODE,
  input wire logic [DW-1:0]         IMM_DATA,
  input wire logic [DW-1:0]         MEM_RDATA,
  input wire logic [DW-1:0]         MUL_OPERAND,
  input wire logic                  WORK_LOAD,
  input wire logic [DW-1:0]         WORK_REG,
  input wire logic [DW-1:0]         MUL_RESULT_HIGH,
  input wire logic [DW-1:0]         MEM_WDATA,
  input wire logic                  MEM_WE,
  input wire logic                  OP_DONE,
  input wire logic                  RESULT_NULL,
  input wire logic                  UNSIGNED_OUT,
  input wire logic                  NIBBLE_OUT,
  input wire logic                  SIGNED_WRAP
);
  wire logic [3:0] flg;  // Status bits as one vector
  wire logic       go;   // Request carrying a known code
  assign flg = {RESULT_NULL, UNSIGNED_OUT, NIBBLE_OUT, SIGNED_WRAP};
  assign go  = OP_VALID && OP_CODE != `MADP_OP_NONE && OP_CODE <= `MADP_OP_MUL;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // A request of one given code
  sequence rq(logic [4:0] c);
    OP_VALID && OP_CODE == c;
  endsequence
  a_done_after_go: assert property (go |=> OP_DONE)
    else $error("completion pulse missing");
  a_add_imm_sum: assert property (rq(`MADP_OP_ADD_AI) |=>
    WORK_REG == $past(WORK_REG) + $past(IMM_DATA) && RESULT_NULL == (WORK_REG == 8'h00))
    else $error("immediate add wrong");
  a_sub_imm_borrow: assert property (rq(`MADP_OP_SUB_AI) |=>
    WORK_REG == $past(WORK_REG) - $past(IMM_DATA)
    && UNSIGNED_OUT == ($past(IMM_DATA) > $past(WORK_REG)))
    else $error("immediate subtract wrong");
  a_inc_in_place: assert property (rq(`MADP_OP_INC_M) |=> MEM_WE &&
    MEM_WDATA == $past(MEM_RDATA) + 8'h01 && UNSIGNED_OUT == ($past(MEM_RDATA) == 8'hFF))
    else $error("increment wrong");
  a_dec_in_place: assert property (rq(`MADP_OP_DEC_M) |=> MEM_WE &&
    MEM_WDATA == $past(MEM_RDATA) - 8'h01 && UNSIGNED_OUT == ($past(MEM_RDATA) == 8'h00))
    else $error("decrement wrong");
  // Clear and multiply must leave every status bit alone
  a_clear_keeps_flags: assert property (rq(`MADP_OP_CLR_M) |=>
    MEM_WE && MEM_WDATA == 8'h00 && $stable(flg))
    else $error("clear wrong");
  a_mul_split: assert property (rq(`MADP_OP_MUL) |=>
    {MUL_RESULT_HIGH, WORK_REG} == $past(WORK_REG) * $past(MUL_OPERAND) && $stable(flg))
    else $error("product wrong");
  a_load_ignored: assert property (rq(`MADP_OP_ADD_MA) ##0 WORK_LOAD |=>
    $stable(WORK_REG))
    else $error("working register moved");
  c_mul: cover property (rq(`MADP_OP_MUL));
  c_refused: cover property (OP_VALID && !go);
  c_back_to_back: cover property (go ##1 go);
endmodule // madp_arith_asserts

bind madp_arith_datapath madp_arith_asserts #(.DW(DW)) u_chk (
  .MCLK(MCLK), .RST_N(RST_N), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE),
  .IMM_DATA(IMM_DATA), .MEM_RDATA(MEM_RDATA), .MUL_OPERAND(MUL_OPERAND),
  .WORK_LOAD(WORK_LOAD), .WORK_REG(WORK_REG), .MUL_RESULT_HIGH(MUL_RESULT_HIGH),
  .MEM_WDATA(MEM_WDATA), .MEM_WE(MEM_WE), .OP_DONE(OP_DONE),
  .RESULT_NULL(RESULT_NULL), .UNSIGNED_OUT(UNSIGNED_OUT), .NIBBLE_OUT(NIBBLE_OUT),
  .SIGNED_WRAP(SIGNED_WRAP));

// File: madp_mem_model.sv
`timescale 1ns/1ns
// Data memory: read is combinational, write-back lands one edge late at
// the address held from the request, so no forwarding is offered
module madp_mem_model (
  input  wire logic       clk,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       we,
  output wire logic [7:0] rdata
);
  logic [7:0] mem [16];  // Sixteen bytes
  logic [3:0] waddr;     // Address of the request being written back
  // Distinct preset bytes, so a wrong address shows up as a wrong value
  initial begin
    for (int k = 0; k < 16; k++)
      mem[k] = 8'(k * 29 + 90);
  end
  assign rdata = mem[addr];
  // Write strobe pairs with the address of the previous edge
  always @(posedge clk) begin
    waddr <= addr;
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
endmodule // madp_mem_model

// File: tb_top.sv
`timescale 1ns/1ns
`include "madp_defs.vh"
module tb_top;
  localparam logic N = 1'b0, Y = 1'b1;  // Carry-in and subtract selectors
  logic       MCLK = 1'b0;              // Core clock
  logic       RST_N = 1'b0;             // Reset, active low
  logic       op_valid = 1'b0, work_load = 1'b0;
  logic [4:0] op_code = 5'h00;
  logic [7:0] imm = 8'h00, mul_op = 8'h00, wl_data = 8'h00;
  logic [3:0] addr = 4'h0;
  wire  [7:0] mem_rdata, work_reg, mul_high, mem_wdata;
  wire        mem_we, op_done, f_z, f_c, f_nib, f_wrap;
  logic [7:0] w = 8'h00, mh = 8'h00, wd = 8'h00;  // Expected registers
  logic [3:0] fl = 4'h0;                          // Expected status bits
  logic [7:0] mm [16];                            // Expected memory
  logic       e_we = 1'b0, e_dn = 1'b0, pend = 1'b0;
  int         n_mismatch = 0, tests_run = 0, n;

  // Free-running core clock, 20 ns period
  always #10 MCLK = ~MCLK;

  madp_arith_datapath dut (
    .MCLK(MCLK), .RST_N(RST_N), .OP_VALID(op_valid), .OP_CODE(op_code),
    .IMM_DATA(imm), .MEM_RDATA(mem_rdata), .MUL_OPERAND(mul_op),
    .WORK_LOAD(work_load), .WORK_LOAD_DATA(wl_data), .WORK_REG(work_reg),
    .MUL_RESULT_HIGH(mul_high), .MEM_WDATA(mem_wdata), .MEM_WE(mem_we),
    .OP_DONE(op_done), .RESULT_NULL(f_z), .UNSIGNED_OUT(f_c),
    .NIBBLE_OUT(f_nib), .SIGNED_WRAP(f_wrap));
  madp_mem_model u_mem (.clk(MCLK), .addr(addr), .wdata(mem_wdata), .we(mem_we),
    .rdata(mem_rdata));

  // Four-state compare, so an unknown output never slips through
  task chk(input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h, want %h", $time, seen, exp);
    end
  endtask

  // Subtraction reuses the adder on the inverted subtrahend; carries invert
  function automatic logic [11:0] alu(input logic [7:0] x, y, input logic ci, sb);
    logic [7:0] v;
    logic [8:0] s;
    logic [4:0] h;
    v = sb ? ~y : y;
    s = x + v + (ci ^ sb);
    h = x[3:0] + v[3:0] + (ci ^ sb);
    alu = {s[7:0] == 8'h00, s[8] ^ sb, h[4] ^ sb, x[7] == v[7] && s[7] != x[7], s[7:0]};
  endfunction

  // One request; the mirror moves at the edge that takes it
  task automatic op(input logic [4:0] c, input logic [7:0] i, k, input logic [3:0] a);
    logic [7:0]  m;
    logic [11:0] r;
    logic        tom, ok, cf;
    {op_valid, work_load, op_code, imm, mul_op, addr, wl_data} <=
      {1'b1, 1'($urandom), c, i, k, a, 8'($urandom)};
    @(posedge MCLK);
    m = mm[a];
    cf = fl[2];
    ok = 1'b1;
    tom = c inside {`MADP_OP_ADD_MA, `MADP_OP_ADDC_MA, `MADP_OP_ADDC_M, `MADP_OP_NADD_MA,
      `MADP_OP_SUB_MA, `MADP_OP_SUBC_MA, `MADP_OP_SUBC_M, `MADP_OP_INC_M, `MADP_OP_DEC_M,
      `MADP_OP_CLR_M};
    case (c)
      `MADP_OP_ADD_AI: r = alu(w, i, N, N);
      `MADP_OP_ADD_AM, `MADP_OP_ADD_MA: r = alu(w, m, N, N);
      `MADP_OP_ADDC_AM, `MADP_OP_ADDC_MA: r = alu(w, m, cf, N);
      `MADP_OP_ADDC_A: r = alu(w, 8'h00, cf, N);
      `MADP_OP_ADDC_M: r = alu(m, 8'h00, cf, N);
      `MADP_OP_NADD_AM: r = alu(m, w, N, Y);
      `MADP_OP_NADD_MA: r = alu(w, m, N, Y);
      `MADP_OP_SUB_AI: r = alu(w, i, N, Y);
      `MADP_OP_SUB_AM: r = alu(w, m, N, Y);
      `MADP_OP_SUB_MA: r = alu(m, w, N, Y);
      `MADP_OP_SUBC_AM: r = alu(w, m, cf, Y);
      `MADP_OP_SUBC_MA: r = alu(m, w, cf, Y);
      `MADP_OP_SUBC_A: r = alu(w, 8'h00, cf, Y);
      `MADP_OP_SUBC_M: r = alu(m, 8'h00, cf, Y);
      `MADP_OP_INC_M: r = alu(m, 8'h01, N, N);
      `MADP_OP_DEC_M: r = alu(m, 8'h01, N, Y);
      `MADP_OP_CLR_M: r = {fl, 8'h00};
      `MADP_OP_MUL: begin
        mh = 8'((16'(w) * k) >> 8);
        r = {fl, w * k};
      end
      default: ok = 1'b0;  // Refused codes change nothing
    endcase
    if (ok && tom) begin
      mm[a] = r[7:0];
      wd = r[7:0];
    end else if (ok) begin
      w = r[7:0];
    end
    fl = ok ? r[11:8] : fl;
    {e_we, e_dn, pend} = {ok & tom, ok, 1'b1};
  endtask

  // Plain load of the working register
  task ld(input logic [7:0] d);
    {op_valid, work_load, wl_data} <= {1'b0, 1'b1, d};
    @(posedge MCLK);
    {w, e_we, e_dn, pend} = {d, 1'b0, 1'b0, 1'b1};
  endtask

  task rst(input int cyc);
    {w, mh, wd, fl, e_we, e_dn, pend} = '0;
    RST_N <= 1'b0;
    repeat (cyc) @(posedge MCLK);
    RST_N <= 1'b1;
    pend = 1'b1;
  endtask

  // Registered outputs are settled by the falling edge
  always @(negedge MCLK) begin
    if (pend) begin
      pend = 1'b0;
      chk({work_reg, mul_high}, {w, mh});
      chk({mem_wdata, 7'h00, mem_we}, {wd, 7'h00, e_we});
      chk({11'h000, op_done, f_z, f_c, f_nib, f_wrap}, {11'h000, e_dn, fl});
    end
  end

  // Single end of run, reached by the tests and by the watchdog alike
  task wrap_up;
    $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Directed corners first, then seeded random requests and a second reset
  initial begin
    void'($urandom(32'hE1A80F50));
    rst(16);
    for (n = 0; n < 16; n++)
      mm[n] = u_mem.mem[n];
    ld(8'hFF);
    op(`MADP_OP_ADD_AI, 8'h01, 8'h00, 4'h0);  // Wraps to zero with carries out
    op(`MADP_OP_ADDC_A, 8'h00, 8'h00, 4'h1);
    ld(8'h7F);
    op(`MADP_OP_ADD_AI, 8'h01, 8'h00, 4'h0);  // Signed overflow
    ld(8'h00);
    op(`MADP_OP_SUB_AI, 8'h01, 8'h00, 4'h0);  // Borrow out
    op(`MADP_OP_SUBC_A, 8'h00, 8'h00, 4'h1);
    ld(8'hA5);
    op(`MADP_OP_MUL, 8'h00, 8'h5A, 4'h0);
    op(`MADP_OP_CLR_M, 8'h00, 8'h00, 4'h4);
    op(`MADP_OP_NONE, 8'h00, 8'h00, 4'h0);
    op(`MADP_OP_DEC_M, 8'h00, 8'h00, 4'h4);   // Zero byte borrows
    op(`MADP_OP_NONE, 8'h00, 8'h00, 4'h0);
    op(`MADP_OP_INC_M, 8'h00, 8'h00, 4'h4);   // All-ones byte carries
    for (n = 0; n < 32; n++)
      op(5'(n), 8'($urandom), 8'($urandom), 4'(n));
    // Alternate address parity so a late write-back is never read back
    for (n = 0; n < 400; n++)
      op(5'($urandom % 22), 8'($urandom), 8'($urandom), {3'($urandom), n[0]});
    op(`MADP_OP_NONE, 8'h00, 8'h00, 4'h0);
    rst(3);
    op(`MADP_OP_ADD_MA, 8'h00, 8'h00, 4'h5);
    op(`MADP_OP_NONE, 8'h00, 8'h00, 4'h0);
    repeat (2) @(posedge MCLK);
    wrap_up;
  end

  // Watchdog: the tests need about 500 cycles, so this margin means a hang
  initial begin
    repeat (3000) @(posedge MCLK);
    n_mismatch++;
    wrap_up;
  end
endmodule // tb_top
